/* hw/ctv_pkg.sv */
package ctv_pkg;
  // register word indices on the bus (byte address = 4 * index)
  localparam logic [2:0] IDX_YEAR = 3'h0;
  localparam logic [2:0] IDX_MONTH_DAY_VALUE = 3'h1;
  localparam logic [2:0] IDX_WKHR = 3'h2;
  localparam logic [2:0] IDX_MINUTE_SECOND_VALUE = 3'h3;
  localparam logic [2:0] IDX_CTRL = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  // control fields
  localparam int CTRL_UNLOCK_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // timing
  localparam int CLK_HZ = 250000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  // field masks of implemented bits
  localparam logic [15:0] MASK_YEAR = 16'h00FF;
  localparam logic [15:0] MASK_MONTH_DAY_VALUE = 16'h1F3F;
  localparam logic [15:0] MASK_WKHR = 16'h073F;
  localparam logic [15:0] MASK_MINUTE_SECOND_VALUE = 16'h7F7F;
  // reset values: 2000-01-01, weekday 0, 00:00:00
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [4:0] RST_MONTH = 5'h01;
  localparam logic [5:0] RST_DAY = 6'h01;

  typedef struct packed {
    logic [3:0] year_tens_digit;
    logic [3:0] year_units_digit;
    logic month_tens_digit;
    logic [3:0] month_units_digit;
    logic [1:0] date_tens_digit;
    logic [3:0] date_units_digit;
    logic [2:0] weekday_number;
    logic [1:0] hour_tens_digit;
    logic [3:0] hour_units_digit;
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_units_digit;
    logic [2:0] second_tens_digit;
    logic [3:0] second_units_digit;
  } ctv_time_t;
endpackage

/* hw/ctv_calendar_time_value_regs.sv */
// Overview of operation
// [RULE1] The year register keeps the year tens BCD digit 0..9 in bits 7 to 4.
// [RULE2] The year register keeps the year units BCD digit 0..9 in bits 3 to 0.
// [RULE3] Every unimplemented bit of the four time registers reads as zero, incl. year 15..8.
// [RULE4] Writes to year, month/day and weekday/hour land only while the unlock bit is 1.
// [RULE5] The month/day register keeps the month tens digit 0 or 1 at bit 12.
// [RULE6] The month/day register keeps the month units BCD digit 0..9 in bits 11 to 8.
// [RULE7] The month/day register keeps the date tens BCD digit 0..3 in bits 5 to 4.
// [RULE8] The month/day register keeps the date units BCD digit 0..9 in bits 3 to 0.
// [RULE9] The weekday/hour register keeps the weekday 0..6 in bits 10 to 8.
// [RULE10] The weekday/hour register keeps the hour tens BCD digit 0..2 in bits 5 to 4.
// [RULE11] The weekday/hour register keeps the hour units BCD digit 0..9 in bits 3 to 0.
// [RULE12] The minute/second register keeps the minute tens BCD digit 0..5 in bits 14 to 12.
// [RULE13] The minute/second register keeps the minute units BCD digit 0..9 in bits 11 to 8.
// [RULE14] The minute/second register keeps the second tens BCD digit 0..5 in bits 6 to 4.
// [RULE15] The minute/second register keeps the second units BCD digit 0..9 in bits 3 to 0.
// [RULE16] The time advances once per second with decimal carries between fields.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ctv_calendar_time_value_regs #(
  parameter int TICK_CYCLES = ctv_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  // second tick, one cycle per second
  output logic SECOND_TICK
);
  initial
  begin
    if (TICK_CYCLES < 2)
      $error("TICK_CYCLES must be at least 2");
  end

  ctv_pkg::ctv_time_t tm;
  logic clock_write_unlock;
  logic run;
  logic [31:0] tick_cnt;
  logic done;
  logic [2:0] idx;
  logic mapped;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic wr_go;

  // bcd digit increment with wrap at a limit
  function automatic logic [3:0] bcd_inc(input logic [3:0] d, input logic [3:0] lim);
    bcd_inc = (d >= lim) ? 4'h0 : d + 4'h1;
  endfunction

  // last day of the month as two bcd digits; leap year when year mod 4 is 0
  function automatic logic [5:0] last_day(input ctv_pkg::ctv_time_t t);
    logic [6:0] yr;
    logic leap;
    yr = 7'(t.year_tens_digit * 10) + 7'(t.year_units_digit);
    leap = (yr[1:0] == 2'h0);
    last_day = 6'h31;
    unique case ({t.month_tens_digit, t.month_units_digit})
      5'h02: last_day = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
      default: last_day = 6'h31;
    endcase
  endfunction

  // one wait state: waitrequest high on the first request cycle, low on the reply cycle after it
  assign idx = AVS_ADDRESS[4:2];
  assign mapped = (AVS_ADDRESS[1:0] == 2'h0) && (idx <= ctv_pkg::IDX_STATUS);
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !done;
  assign wr_go = AVS_WRITE && done && mapped;

  always_ff @(posedge CLK)
  begin
    if (RST)
      done <= 1'b0;
    else
      done <= (AVS_READ || AVS_WRITE) && !done;
  end

  // byte enables merge the written halfword over the stored one
  always_comb
  begin
    wdat = rdat;
    if (AVS_BYTEENABLE[0])
      wdat[7:0] = AVS_WRITEDATA[7:0];
    if (AVS_BYTEENABLE[1])
      wdat[15:8] = AVS_WRITEDATA[15:8];
  end

  // [RULE3] zero unused bits
  always_comb
  begin
    rdat = 16'h0000;
    unique case (idx)
      ctv_pkg::IDX_YEAR: rdat = {8'h00, tm.year_tens_digit, tm.year_units_digit};
      ctv_pkg::IDX_MONTH_DAY_VALUE: rdat = {3'h0, tm.month_tens_digit, tm.month_units_digit,
                                  2'h0, tm.date_tens_digit, tm.date_units_digit};
      ctv_pkg::IDX_WKHR: rdat = {5'h00, tm.weekday_number, 2'h0, tm.hour_tens_digit,
                                 tm.hour_units_digit};
      ctv_pkg::IDX_MINUTE_SECOND_VALUE: rdat = {1'b0, tm.minute_tens_digit, tm.minute_units_digit,
                                   1'b0, tm.second_tens_digit, tm.second_units_digit};
      ctv_pkg::IDX_CTRL: rdat = {14'h0000, run, clock_write_unlock};
      ctv_pkg::IDX_STATUS: rdat = {15'h0000, tm.second_units_digit[0]};
      default: rdat = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      AVS_READDATA <= 32'h0000_0000;
      AVS_RESPONSE <= 2'h0;
    end
    else if ((AVS_READ || AVS_WRITE) && !done)
    begin
      AVS_READDATA <= {16'h0000, rdat};
      AVS_RESPONSE <= mapped ? 2'h0 : 2'h3;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      clock_write_unlock <= ctv_pkg::CTRL_RESET[ctv_pkg::CTRL_UNLOCK_BIT];
      run <= ctv_pkg::CTRL_RESET[ctv_pkg::CTRL_RUN_BIT];
    end
    else if (wr_go && idx == ctv_pkg::IDX_CTRL)
    begin
      clock_write_unlock <= wdat[ctv_pkg::CTRL_UNLOCK_BIT];
      run <= wdat[ctv_pkg::CTRL_RUN_BIT];
    end
  end

  // second prescaler; restarts when the seconds are written
  always_ff @(posedge CLK)
  begin
    if (RST || !run || (wr_go && idx == ctv_pkg::IDX_MINUTE_SECOND_VALUE))
      tick_cnt <= 32'h0000_0000;
    else if (tick_cnt == 32'(TICK_CYCLES - 1))
      tick_cnt <= 32'h0000_0000;
    else
      tick_cnt <= tick_cnt + 32'h0000_0001;
  end
  assign SECOND_TICK = run && (tick_cnt == 32'(TICK_CYCLES - 1));

  // a software write wins over the tick in the same cycle; illegal digits written
  // by software are kept as given and recover on the next wrap
  always_ff @(posedge CLK)
  begin
    logic sc, mc, hc, dc, moc;
    sc = 1'b0;
    mc = 1'b0;
    hc = 1'b0;
    dc = 1'b0;
    moc = 1'b0;
    if (RST)
    begin
      {tm.year_tens_digit, tm.year_units_digit} <= ctv_pkg::RST_YEAR;
      {tm.month_tens_digit, tm.month_units_digit} <= ctv_pkg::RST_MONTH;
      {tm.date_tens_digit, tm.date_units_digit} <= ctv_pkg::RST_DAY;
      tm.weekday_number <= 3'h0;
      {tm.hour_tens_digit, tm.hour_units_digit} <= 6'h00;
      {tm.minute_tens_digit, tm.minute_units_digit} <= 7'h00;
      {tm.second_tens_digit, tm.second_units_digit} <= 7'h00;
    end
    else if (wr_go && idx == ctv_pkg::IDX_MINUTE_SECOND_VALUE)
    begin
      // [RULE12] minute tens field
      tm.minute_tens_digit <= wdat[14:12];
      // [RULE13] minute units field
      tm.minute_units_digit <= wdat[11:8];
      // [RULE14] second tens field
      tm.second_tens_digit <= wdat[6:4];
      // [RULE15] second units field
      tm.second_units_digit <= wdat[3:0];
    end
    else if (wr_go && clock_write_unlock && idx == ctv_pkg::IDX_YEAR)
    begin
      // [RULE4] unlock gates write
      // [RULE1] year tens field
      tm.year_tens_digit <= wdat[7:4];
      // [RULE2] year units field
      tm.year_units_digit <= wdat[3:0];
    end
    else if (wr_go && clock_write_unlock && idx == ctv_pkg::IDX_MONTH_DAY_VALUE)
    begin
      // [RULE4] unlock gates write
      // [RULE5] month tens bit
      tm.month_tens_digit <= wdat[12];
      // [RULE6] month units field
      tm.month_units_digit <= wdat[11:8];
      // [RULE7] date tens field
      tm.date_tens_digit <= wdat[5:4];
      // [RULE8] date units field
      tm.date_units_digit <= wdat[3:0];
    end
    else if (wr_go && clock_write_unlock && idx == ctv_pkg::IDX_WKHR)
    begin
      // [RULE4] unlock gates write
      // [RULE9] weekday field
      tm.weekday_number <= wdat[10:8];
      // [RULE10] hour tens field
      tm.hour_tens_digit <= wdat[5:4];
      // [RULE11] hour units field
      tm.hour_units_digit <= wdat[3:0];
    end
    else if (SECOND_TICK)
    begin
      // [RULE16] decimal carry chain
      tm.second_units_digit <= bcd_inc(tm.second_units_digit, 4'h9);
      if (tm.second_units_digit >= 4'h9)
      begin
        tm.second_tens_digit <= 3'(bcd_inc({1'b0, tm.second_tens_digit}, 4'h5));
        sc = (tm.second_tens_digit >= 3'h5);
      end
      if (sc)
        tm.minute_units_digit <= bcd_inc(tm.minute_units_digit, 4'h9);
      if (sc && tm.minute_units_digit >= 4'h9)
      begin
        tm.minute_tens_digit <= 3'(bcd_inc({1'b0, tm.minute_tens_digit}, 4'h5));
        mc = (tm.minute_tens_digit >= 3'h5);
      end
      if (mc)
      begin
        hc = ({tm.hour_tens_digit, tm.hour_units_digit} >= 6'h23);
        if (hc)
          {tm.hour_tens_digit, tm.hour_units_digit} <= 6'h00;
        else if (tm.hour_units_digit >= 4'h9)
          {tm.hour_tens_digit, tm.hour_units_digit} <= {tm.hour_tens_digit + 2'h1, 4'h0};
        else
          tm.hour_units_digit <= tm.hour_units_digit + 4'h1;
      end
      if (hc)
      begin
        tm.weekday_number <= (tm.weekday_number >= 3'h6) ? 3'h0 : tm.weekday_number + 3'h1;
        dc = ({tm.date_tens_digit, tm.date_units_digit} >= last_day(tm));
        if (dc)
          {tm.date_tens_digit, tm.date_units_digit} <= 6'h01;
        else if (tm.date_units_digit >= 4'h9)
          {tm.date_tens_digit, tm.date_units_digit} <= {tm.date_tens_digit + 2'h1, 4'h0};
        else
          tm.date_units_digit <= tm.date_units_digit + 4'h1;
      end
      if (dc)
      begin
        moc = ({tm.month_tens_digit, tm.month_units_digit} >= 5'h12);
        if (moc)
          {tm.month_tens_digit, tm.month_units_digit} <= 5'h01;
        else if (tm.month_units_digit >= 4'h9)
          {tm.month_tens_digit, tm.month_units_digit} <= 5'h10;
        else
          tm.month_units_digit <= tm.month_units_digit + 4'h1;
      end
      if (moc)
      begin
        tm.year_units_digit <= bcd_inc(tm.year_units_digit, 4'h9);
        if (tm.year_units_digit >= 4'h9)
          tm.year_tens_digit <= bcd_inc(tm.year_tens_digit, 4'h9);
      end
    end
  end
endmodule
`default_nettype wire

/* dv/ctv_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module ctv_regs_checker #(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // bus and tick
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [1:0] AVS_RESPONSE,
  input wire logic SECOND_TICK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [15:0] rd;
  assign rd = AVS_READDATA[15:0];
  sequence s_start;
    $rose(AVS_READ || AVS_WRITE);
  endsequence
  sequence s_rd(int k);
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 5'(k * 4);
  endsequence
  a_one_wait: assert property (s_start |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("request not answered after one wait state");
  a_upper_zero: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_year_field: assert property (s_rd(0) |->
    rd[15:8] == 8'h00 && rd[7:4] <= 4'h9 && rd[3:0] <= 4'h9)
    else $error("year word out of range");
  a_month_day_value_field: assert property (s_rd(1) |->
    rd[15:13] == 3'h0 && rd[7:6] == 2'h0 && rd[11:8] <= 4'h9 && rd[3:0] <= 4'h9)
    else $error("month day word out of range");
  a_wkhr_field: assert property (s_rd(2) |->
    rd[15:11] == 5'h00 && rd[7:6] == 2'h0 && rd[10:8] <= 3'h6 && rd[5:4] <= 2'h2
    && rd[3:0] <= 4'h9)
    else $error("weekday hour word out of range");
  a_minute_second_value_field: assert property (s_rd(3) |->
    rd[15] == 1'b0 && rd[7] == 1'b0 && rd[14:12] <= 3'h5 && rd[11:8] <= 4'h9
    && rd[6:4] <= 3'h5 && rd[3:0] <= 4'h9)
    else $error("minute second word out of range");
  a_tick_pulse: assert property (SECOND_TICK |=> !SECOND_TICK)
    else $error("tick longer than one cycle");
  a_bad_resp: assert property (s_rd(6) or s_rd(7) |-> AVS_RESPONSE == 2'h3)
    else $error("unmapped read not flagged");
  a_ok_resp: assert property (s_rd(0) or s_rd(3) |-> AVS_RESPONSE == 2'h0)
    else $error("mapped read flagged");
endmodule
bind ctv_calendar_time_value_regs ctv_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_RESPONSE(AVS_RESPONSE), .SECOND_TICK(SECOND_TICK));
`default_nettype wire

/* dv/test_calendar_time_value_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("unexpected %s exp %h got %h", nm, ex, got); num_errors++; end end
module test_calendar_time_value_regs;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [1:0] AVS_RESPONSE;
  logic SECOND_TICK;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2 CLK = ~CLK;
  // short second so the carry scenario fits the run
  ctv_calendar_time_value_regs #(.TICK_CYCLES(20)) u_ctv_calendar_time_value_regs (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_RESPONSE(AVS_RESPONSE), .SECOND_TICK(SECOND_TICK));
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request held until the rising edge that samples waitrequest low
  task automatic acc(input logic we, input logic [2:0] idx, input logic [15:0] d);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITE <= we;
    AVS_READ <= ~we;
    AVS_WRITEDATA <= {16'h0000, d};
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [2:0] idx, input logic [17:0] ex);
    exp_q.push_back(ex);
    acc(1'b0, idx, 16'h0000);
  endtask
  function automatic logic [3:0] r(input int n);
    r = 4'($urandom_range(n));
  endfunction
  function automatic logic [15:0] legal(input logic [2:0] idx);
    case (idx)
      3'h0: legal = {8'h00, r(9), r(9)};
      3'h1: legal = {r(1), r(9), r(3), r(9)};
      3'h2: legal = {4'h0, r(6), r(2), r(9)};
      default: legal = {r(5), r(9), r(5), r(9)};
    endcase
  endfunction
  always @(posedge CLK)
    if (AVS_READ && AVS_WAITREQUEST === 1'b0)
    begin
      e = exp_q.pop_front();
      `CHK("read word", e, {AVS_RESPONSE, AVS_READDATA[15:0]})
    end
  always @(posedge CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    logic [2:0] k;
    logic [15:0] d;
    void'($urandom(97));
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(ctv_pkg::IDX_YEAR, 18'h00000);
    rd(ctv_pkg::IDX_MONTH_DAY_VALUE, 18'h00101);
    acc(1'b1, ctv_pkg::IDX_CTRL, 16'h0000);
    acc(1'b1, ctv_pkg::IDX_YEAR, 16'h0099);
    rd(ctv_pkg::IDX_YEAR, 18'h00000);
    acc(1'b1, ctv_pkg::IDX_WKHR, 16'h0623);
    rd(ctv_pkg::IDX_WKHR, 18'h00000);
    d = legal(3'h3);
    acc(1'b1, ctv_pkg::IDX_MINUTE_SECOND_VALUE, d);
    rd(ctv_pkg::IDX_MINUTE_SECOND_VALUE, {2'h0, d});
    acc(1'b1, ctv_pkg::IDX_CTRL, 16'h0001);
    // bit 15 is unused in all four words, bit 7 in all but the year (tens digit there)
    repeat (12)
    begin
      k = 3'($urandom_range(3));
      d = legal(k);
      acc(1'b1, k, d | ((k == 3'h0) ? 16'h8000 : 16'h8080));
      rd(k, {2'h0, d});
    end
    acc(1'b1, 3'h6, 16'hFFFF);
    rd(3'h6, 18'h30000);
    acc(1'b1, ctv_pkg::IDX_YEAR, 16'h0099);
    acc(1'b1, ctv_pkg::IDX_MONTH_DAY_VALUE, 16'h1231);
    acc(1'b1, ctv_pkg::IDX_WKHR, 16'h0623);
    acc(1'b1, ctv_pkg::IDX_MINUTE_SECOND_VALUE, 16'h5959);
    acc(1'b1, ctv_pkg::IDX_CTRL, 16'h0003);
    while (SECOND_TICK !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    acc(1'b1, ctv_pkg::IDX_CTRL, 16'h0001);
    rd(ctv_pkg::IDX_YEAR, 18'h00000);
    rd(ctv_pkg::IDX_MONTH_DAY_VALUE, 18'h00101);
    rd(ctv_pkg::IDX_WKHR, 18'h00000);
    rd(ctv_pkg::IDX_MINUTE_SECOND_VALUE, 18'h00000);
    finish_test();
  end
endmodule
`default_nettype wire
